// file: rtl/scd_delay_regs.sv
// scd_delay_regs: sampling clock delay and filter control registers
`timescale 1ns/1ns
// What this block does
// - coarse code bits 15:4, 0 none, 2431 max
// - codes 2432 and up saturate at max
// - delay only active with either select bit
// - adjust select enables coarse and fine codes
// - stabilizer bit 2 resets one, zero disables
// - fine code bits 15:10, 36 fs steps
// - filter select enables delay and filter, overrides
// - filter frequency field is thermometer coded
// - each coarse step adds about 340 fs
module scd_delay_regs
    import scd_pkg::*;
#(
    parameter int unsigned STEP_CW = 4                  // filter step count width
) (
    input  wire logic                    clock,         // 25 MHz system clock
    input  wire logic                    rst_b,         // synchronous reset, active low
    input  wire logic [ADDR_W-1:0]       reg_addr,      // register address
    input  wire logic                    reg_wr_en,     // write strobe, one cycle
    input  wire logic [DATA_W-1:0]       reg_wdata,     // write data
    input  wire logic                    reg_rd_en,     // read strobe, one cycle
    output logic      [DATA_W-1:0]       reg_rdata,     // read data, held
    output logic                         reg_rd_valid,  // read data valid pulse
    output logic [COARSE_CODE_W-1:0]     coarse_delay_eff, // applied coarse code
    output logic [FINE_CODE_W-1:0]       fine_delay_eff,   // applied fine code
    output logic [COARSE_FS_W-1:0]       coarse_delay_fs,  // coarse delay in fs
    output logic [FINE_FS_W-1:0]         fine_delay_fs,    // fine delay in fs
    output logic                         adjust_active,    // delay path in use
    output logic                         lc_filter_en,     // jitter filter on
    output logic [FILT_CODE_W-1:0]       filter_freq_code, // filter thermometer code
    output logic [STEP_CW-1:0]           filter_steps,     // filter code ones count
    output logic                         filter_code_ok,   // clean thermometer code
    output logic                         duty_cycle_stabilizer_on // stabilizer enable
);

    // ------------------------------------------------------------
    // stored fields
    // ------------------------------------------------------------
    logic [COARSE_CODE_W-1:0] coarse_delay_code_ff;     // coarse code field
    logic                     delay_adjust_select_ff;   // plain adjust enable
    logic                     dcs_on_ff;                // stabilizer control
    logic [FINE_CODE_W-1:0]   fine_delay_code_ff;       // fine code field
    logic                     delay_and_filter_select_ff; // adjust plus filter enable
    logic [FILT_CODE_W-1:0]   filter_freq_thermo_code_ff; // filter frequency field

    // ------------------------------------------------------------
    // output flops
    // ------------------------------------------------------------
    logic [DATA_W-1:0]        rdata_ff;                 // read data
    logic                     rd_valid_ff;              // read valid
    logic [COARSE_CODE_W-1:0] coarse_eff_ff;            // applied coarse code
    logic [FINE_CODE_W-1:0]   fine_eff_ff;              // applied fine code
    logic [COARSE_FS_W-1:0]   coarse_fs_ff;             // coarse delay fs
    logic [FINE_FS_W-1:0]     fine_fs_ff;               // fine delay fs
    logic                     active_ff;                // delay path active
    logic                     filt_en_ff;               // filter enable
    logic [FILT_CODE_W-1:0]   filt_code_ff;             // filter code copy
    logic [STEP_CW-1:0]       filt_steps_ff;            // filter steps
    logic                     filt_ok_ff;               // filter code clean
    logic                     dcs_out_ff;               // stabilizer output

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic                     wr_coarse;                // write to coarse reg
    logic                     wr_fine;                  // write to fine reg
    logic                     nxt_active;               // either select set
    logic [COARSE_CODE_W-1:0] nxt_coarse_sat;           // saturated coarse code
    logic [COARSE_CODE_W-1:0] nxt_coarse_eff;           // gated coarse code
    logic [FINE_CODE_W-1:0]   nxt_fine_eff;             // gated fine code
    logic [DATA_W-1:0]        nxt_rdata;                // read mux
    logic [STEP_CW-1:0]       therm_steps;              // decoded steps
    logic                     therm_ok;                 // decoded validity

    assign wr_coarse = reg_wr_en && (reg_addr == ADDR_COARSE);
    assign wr_fine   = reg_wr_en && (reg_addr == ADDR_FINE_FILTER);

    // ------------------------------------------------------------
    // coarse register storage
    // ------------------------------------------------------------
    // reserved bits 1:0 are not stored; host keeps them zero
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            coarse_delay_code_ff   <= RST_COARSE[COARSE_CODE_MSB:COARSE_CODE_LSB];
            delay_adjust_select_ff <= RST_COARSE[ADJ_SEL_BIT];
            dcs_on_ff              <= RST_COARSE[DCS_BIT];
        end else if (wr_coarse) begin
            coarse_delay_code_ff   <= reg_wdata[COARSE_CODE_MSB:COARSE_CODE_LSB];
            delay_adjust_select_ff <= reg_wdata[ADJ_SEL_BIT];
            dcs_on_ff              <= reg_wdata[DCS_BIT];
        end
    end

    // ------------------------------------------------------------
    // fine and filter register storage
    // ------------------------------------------------------------
    // reserved bit 9 is not stored; host keeps it zero
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            fine_delay_code_ff         <= RST_FINE_FILTER[FINE_CODE_MSB:FINE_CODE_LSB];
            delay_and_filter_select_ff <= RST_FINE_FILTER[FILT_SEL_BIT];
            filter_freq_thermo_code_ff <= RST_FINE_FILTER[FILT_CODE_MSB:0];
        end else if (wr_fine) begin
            fine_delay_code_ff         <= reg_wdata[FINE_CODE_MSB:FINE_CODE_LSB];
            delay_and_filter_select_ff <= reg_wdata[FILT_SEL_BIT];
            filter_freq_thermo_code_ff <= reg_wdata[FILT_CODE_MSB:0];
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // read mux, reserved bits and unmapped addresses read zero
    always_comb begin
        nxt_rdata = '0;
        if (reg_addr == ADDR_COARSE) begin
            nxt_rdata[COARSE_CODE_MSB:COARSE_CODE_LSB] = coarse_delay_code_ff;
            nxt_rdata[ADJ_SEL_BIT]                     = delay_adjust_select_ff;
            nxt_rdata[DCS_BIT]                         = dcs_on_ff;
        end else if (reg_addr == ADDR_FINE_FILTER) begin
            nxt_rdata[FINE_CODE_MSB:FINE_CODE_LSB]     = fine_delay_code_ff;
            nxt_rdata[FILT_SEL_BIT]                    = delay_and_filter_select_ff;
            nxt_rdata[FILT_CODE_MSB:0]                 = filter_freq_thermo_code_ff;
        end
    end

    // read data held until the next read
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rdata_ff    <= '0;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= reg_rd_en;
            if (reg_rd_en) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // delay path selection
    // ------------------------------------------------------------
    // filter select stands for adjust select, so an or covers both
    always_comb begin
        nxt_active     = delay_adjust_select_ff || delay_and_filter_select_ff;
        nxt_coarse_sat = (coarse_delay_code_ff >= COARSE_SAT_CODE)
                         ? COARSE_MAX_CODE : coarse_delay_code_ff;
        nxt_coarse_eff = nxt_active ? nxt_coarse_sat : '0;
        nxt_fine_eff   = nxt_active ? fine_delay_code_ff : '0;
    end

    // applied codes and their delay in femtoseconds
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            active_ff     <= 1'b0;
            coarse_eff_ff <= '0;
            fine_eff_ff   <= '0;
            coarse_fs_ff  <= '0;
            fine_fs_ff    <= '0;
        end else begin
            active_ff     <= nxt_active;
            coarse_eff_ff <= nxt_coarse_eff;
            fine_eff_ff   <= nxt_fine_eff;
            // operands widened first so the product cannot wrap at code width
            coarse_fs_ff  <= COARSE_FS_W'(coarse_eff_ff) * COARSE_FS_W'(COARSE_STEP_FS);
            fine_fs_ff    <= FINE_FS_W'(fine_eff_ff) * FINE_FS_W'(FINE_STEP_FS);
        end
    end

    // ------------------------------------------------------------
    // filter and stabilizer outputs
    // ------------------------------------------------------------
    scd_thermo_decode #(
        .W      (FILT_CODE_W),
        .CW     (STEP_CW)
    ) u_thermo (
        .code   (filter_freq_thermo_code_ff),
        .steps  (therm_steps),
        .valid  (therm_ok)
    );

    // more steps lower the filter centre frequency
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            filt_en_ff    <= 1'b0;
            filt_code_ff  <= '0;
            filt_steps_ff <= '0;
            filt_ok_ff    <= 1'b1;
            dcs_out_ff    <= RST_COARSE[DCS_BIT];
        end else begin
            filt_en_ff    <= delay_and_filter_select_ff;
            filt_code_ff  <= filter_freq_thermo_code_ff;
            filt_steps_ff <= therm_steps;
            filt_ok_ff    <= therm_ok;
            dcs_out_ff    <= dcs_on_ff;
        end
    end

    // ------------------------------------------------------------
    // output drive
    // ------------------------------------------------------------
    assign reg_rdata                = rdata_ff;
    assign reg_rd_valid             = rd_valid_ff;
    assign coarse_delay_eff         = coarse_eff_ff;
    assign fine_delay_eff           = fine_eff_ff;
    assign coarse_delay_fs          = coarse_fs_ff;
    assign fine_delay_fs            = fine_fs_ff;
    assign adjust_active            = active_ff;
    assign lc_filter_en             = filt_en_ff;
    assign filter_freq_code         = filt_code_ff;
    assign filter_steps             = filt_steps_ff;
    assign filter_code_ok           = filt_ok_ff;
    assign duty_cycle_stabilizer_on = dcs_out_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_coarse_saturate: assert property (@(posedge clock) disable iff (!rst_b)
        (nxt_active && coarse_delay_code_ff >= COARSE_SAT_CODE)
        |=> coarse_eff_ff == COARSE_MAX_CODE)
        else $error("coarse code above limit not saturated");

    a_coarse_pass: assert property (@(posedge clock) disable iff (!rst_b)
        (delay_adjust_select_ff && coarse_delay_code_ff < COARSE_SAT_CODE)
        |=> coarse_eff_ff == $past(coarse_delay_code_ff)
            && fine_eff_ff == $past(fine_delay_code_ff))
        else $error("adjust select did not apply codes");

    a_delay_idle: assert property (@(posedge clock) disable iff (!rst_b)
        (!delay_adjust_select_ff && !delay_and_filter_select_ff)
        |=> !active_ff && coarse_eff_ff == '0 ##1 coarse_fs_ff == '0)
        else $error("delay applied without a select bit");

    a_filter_override: assert property (@(posedge clock) disable iff (!rst_b)
        delay_and_filter_select_ff |=> active_ff && filt_en_ff)
        else $error("filter select did not enable delay and filter");

    a_coarse_scale: assert property (@(posedge clock) disable iff (!rst_b)
        coarse_eff_ff == COARSE_MAX_CODE |=> coarse_fs_ff == 20'hC9CAC)
        else $error("coarse step scaling wrong");

    a_fine_scale: assert property (@(posedge clock) disable iff (!rst_b)
        fine_eff_ff == 6'h3F |=> fine_fs_ff == 12'h8DC)
        else $error("fine step scaling wrong");

    a_thermo_mid: assert property (@(posedge clock) disable iff (!rst_b)
        filter_freq_thermo_code_ff == 8'h0F |=> filt_steps_ff == 4'h4 && filt_ok_ff)
        else $error("mid filter code not decoded");

    a_dcs_reset: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(rst_b) |-> dcs_on_ff && dcs_out_ff)
        else $error("stabilizer not on after reset");

    a_dcs_clear: assert property (@(posedge clock) disable iff (!rst_b)
        (wr_coarse && !reg_wdata[DCS_BIT]) |=> !dcs_on_ff ##1 !dcs_out_ff)
        else $error("stabilizer not turned off by write");

    a_field_hold: assert property (@(posedge clock) disable iff (!rst_b)
        !reg_wr_en |=> $stable(coarse_delay_code_ff) && $stable(fine_delay_code_ff)
            && $stable(filter_freq_thermo_code_ff) && $stable(dcs_on_ff))
        else $error("field changed without a write");

endmodule : scd_delay_regs

// file: rtl/scd_pkg.sv
// scd_pkg: register map, field layout, reset values and scaling for the clock delay registers
package scd_pkg;

    // ------------------------------------------------------------
    // register addresses on the control interface
    // ------------------------------------------------------------
    localparam int unsigned   ADDR_W            = 4;        // control address width
    localparam int unsigned   DATA_W            = 16;       // register width
    localparam logic [3:0]    ADDR_COARSE       = 4'hC;     // clock_delay_coarse_ctrl
    localparam logic [3:0]    ADDR_FINE_FILTER  = 4'hD;     // clock_delay_fine_filter_ctrl

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0]   RST_COARSE        = 16'h0004; // stabilizer on, no delay
    localparam logic [15:0]   RST_FINE_FILTER   = 16'h0000; // all off

    // ------------------------------------------------------------
    // coarse register fields
    // ------------------------------------------------------------
    localparam int unsigned   COARSE_CODE_MSB   = 15;       // coarse_delay_code top bit
    localparam int unsigned   COARSE_CODE_LSB   = 4;        // coarse_delay_code low bit
    localparam int unsigned   COARSE_CODE_W     = 12;       // coarse code width
    localparam int unsigned   ADJ_SEL_BIT       = 3;        // delay_adjust_select
    localparam int unsigned   DCS_BIT           = 2;        // duty_cycle_stabilizer_on

    // ------------------------------------------------------------
    // fine / filter register fields
    // ------------------------------------------------------------
    localparam int unsigned   FINE_CODE_MSB     = 15;       // fine_delay_code top bit
    localparam int unsigned   FINE_CODE_LSB     = 10;       // fine_delay_code low bit
    localparam int unsigned   FINE_CODE_W       = 6;        // fine code width
    localparam int unsigned   FILT_SEL_BIT      = 8;        // delay_and_filter_select
    localparam int unsigned   FILT_CODE_MSB     = 7;        // filter_freq_thermo_code top bit
    localparam int unsigned   FILT_CODE_W       = 8;        // thermometer width

    // ------------------------------------------------------------
    // delay scaling
    // ------------------------------------------------------------
    localparam logic [11:0]   COARSE_MAX_CODE   = 12'h97F;  // 2431, top valid code
    localparam logic [11:0]   COARSE_SAT_CODE   = 12'h980;  // 2432, saturation start
    localparam logic [9:0]    COARSE_STEP_FS    = 10'h154;  // 340 fs per coarse step
    localparam logic [5:0]    FINE_STEP_FS      = 6'h24;    // 36 fs per fine step
    localparam int unsigned   COARSE_FS_W       = 20;       // up to 826540 fs
    localparam int unsigned   FINE_FS_W         = 12;       // up to 2268 fs

endpackage : scd_pkg

// file: rtl/scd_thermo_decode.sv
// scd_thermo_decode: step count and validity check of a thermometer code
`timescale 1ns/1ns
module scd_thermo_decode #(
    parameter int unsigned W  = 8,                  // thermometer width
    parameter int unsigned CW = $clog2(W + 1)       // count width
) (
    input  wire logic [W-1:0]  code,                // thermometer code
    output logic      [CW-1:0] steps,               // number of ones
    output logic               valid                // ones contiguous from bit 0
);

    // ------------------------------------------------------------
    // count ones and check the code is a clean thermometer
    // ------------------------------------------------------------
    logic [W-1:0] code_inc;                         // code plus one

    // plus one of a clean code has no common bit with the code
    assign code_inc = W'(code + 1'b1);

    // count of set bits, one step each
    always_comb begin
        steps = '0;
        for (int i = 0; i < W; i++) begin
            if (code[i]) begin
                steps = CW'(steps + 1'b1);
            end
        end
        valid = ((code & code_inc) == '0);
    end

endmodule : scd_thermo_decode

// file: sim/tb_top.sv
// tb_top: self-checking bench for the clock delay control registers
`timescale 1ns/1ns
module tb_top
    import scd_pkg::*;
;
    // ------------------------------------------------------------
    // clock, reset and design connections
    // ------------------------------------------------------------
    logic                     clock;            // 25 MHz system clock
    logic                     rst_b;            // synchronous reset, active low
    logic [ADDR_W-1:0]        reg_addr;         // register address
    logic                     reg_wr_en;        // write strobe
    logic [DATA_W-1:0]        reg_wdata;        // write data
    logic                     reg_rd_en;        // read strobe
    logic [DATA_W-1:0]        reg_rdata;        // read data
    logic                     reg_rd_valid;     // read data valid
    logic [COARSE_CODE_W-1:0] coarse_delay_eff; // applied coarse code
    logic [FINE_CODE_W-1:0]   fine_delay_eff;   // applied fine code
    logic [COARSE_FS_W-1:0]   coarse_delay_fs;  // coarse delay in fs
    logic [FINE_FS_W-1:0]     fine_delay_fs;    // fine delay in fs
    logic                     adjust_active;    // delay path in use
    logic                     lc_filter_en;     // jitter filter on
    logic [FILT_CODE_W-1:0]   filter_freq_code; // filter code copy
    logic [3:0]               filter_steps;     // filter ones count
    logic                     filter_code_ok;   // clean thermometer code
    logic                     duty_cycle_stabilizer_on; // stabilizer enable
    int                       bad_count = 0;    // mismatches seen
    int                       n_tests   = 0;    // comparisons made

    // clock generator, 40 ns period
    initial clock = 1'b0;
    always #20 clock = ~clock;

    scd_delay_regs #(.STEP_CW(4)) scd_delay_regs_i (
        .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .coarse_delay_eff(coarse_delay_eff),
        .fine_delay_eff(fine_delay_eff), .coarse_delay_fs(coarse_delay_fs),
        .fine_delay_fs(fine_delay_fs), .adjust_active(adjust_active),
        .lc_filter_en(lc_filter_en), .filter_freq_code(filter_freq_code),
        .filter_steps(filter_steps), .filter_code_ok(filter_code_ok),
        .duty_cycle_stabilizer_on(duty_cycle_stabilizer_on));

    // ------------------------------------------------------------
    // helper tasks
    // ------------------------------------------------------------
    // verdict and end of run
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    // one comparison, counted
    task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
            bad_count++;
        end
    endtask : chk

    // one write cycle, strobe held for exactly one taken edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge clock);
        reg_wr_en <= 1'b0;
        repeat (3) @(posedge clock); // let derived and fs outputs settle
        #1;
    endtask : wr

    // one read cycle, answer awaited under a bound
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        int i;
        @(posedge clock);
        reg_addr  <= a;
        reg_rd_en <= 1'b1;
        @(posedge clock);
        reg_rd_en <= 1'b0;
        #1;
        // valid rises at the taken edge and stands for one cycle only
        for (i = 0; i < 4; i++) begin
            if (reg_rd_valid === 1'b1) break;
            @(posedge clock);
            #1;
        end
        if (i == 4) begin
            $display("ERROR at %0t: read answer missing", $time);
            bad_count++;
            summarize();
        end
        chk(20'(reg_rdata), 20'(exp), "read data");
    endtask : rd

    // delay outputs against expected codes, fs worked out from step sizes
    task automatic chk_delay(input logic [11:0] c, input logic [5:0] f, input logic act);
        chk(20'(coarse_delay_eff), 20'(c), "coarse code");
        chk(20'(fine_delay_eff), 20'(f), "fine code");
        chk(20'(c) * 20'h00154, 20'(coarse_delay_fs), "coarse fs");
        chk(20'(f) * 20'h00024, 20'(fine_delay_fs), "fine fs");
        chk(20'(adjust_active), 20'(act), "adjust active");
    endtask : chk_delay

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        reg_addr = 4'h0;
        reg_wr_en = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd_en = 1'b0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        // reset defaults
        rd(4'hC, 16'h0004);
        rd(4'hD, 16'h0000);
        chk(20'(duty_cycle_stabilizer_on), 20'h00001, "stabilizer");
        chk_delay(12'h000, 6'h00, 1'b0);
        $display("test reset done");
        // saturation above top code, with fine code at full scale
        wr(4'hD, 16'hFC00);
        wr(4'hC, 16'h980C);
        rd(4'hC, 16'h980C);
        chk_delay(12'h97F, 6'h3F, 1'b1);
        wr(4'hC, 16'hFFF8);
        chk_delay(12'h97F, 6'h3F, 1'b1);
        wr(4'hC, 16'h97F8);
        chk_delay(12'h97F, 6'h3F, 1'b1);
        wr(4'hC, 16'h0018);
        chk_delay(12'h001, 6'h3F, 1'b1);
        wr(4'hC, 16'h0008);
        chk_delay(12'h000, 6'h3F, 1'b1);
        $display("test coarse range done");
        // no select bit: codes held but not applied
        wr(4'hC, 16'h1230);
        chk_delay(12'h000, 6'h00, 1'b0);
        chk(20'(lc_filter_en), 20'h00000, "filter off");
        // filter select alone enables delay and filter
        wr(4'hD, 16'h850F);
        chk_delay(12'h123, 6'h21, 1'b1);
        chk(20'(lc_filter_en), 20'h00001, "filter on");
        chk(20'(filter_freq_code), 20'h0000F, "filter code");
        chk(20'(filter_steps), 20'h00004, "filter steps");
        chk(20'(filter_code_ok), 20'h00001, "filter ok");
        // both selects: same delay, adjust bit ignored
        wr(4'hC, 16'h1238);
        chk_delay(12'h123, 6'h21, 1'b1);
        wr(4'hD, 16'h01FF);
        chk(20'(filter_steps), 20'h00008, "filter full");
        wr(4'hD, 16'h0105);
        chk(20'(filter_code_ok), 20'h00000, "filter broken");
        wr(4'hD, 16'h0100);
        chk(20'(filter_steps), 20'h00000, "filter empty");
        chk(20'(filter_code_ok), 20'h00001, "filter zero ok");
        $display("test selects done");
        // reserved bits and stabilizer off
        wr(4'hC, 16'hFFF8);
        rd(4'hC, 16'hFFF8);
        chk(20'(duty_cycle_stabilizer_on), 20'h00000, "stabilizer off");
        wr(4'hD, 16'hFDFF);
        rd(4'hD, 16'hFDFF);
        // unmapped address leaves registers alone
        wr(4'hC, 16'h5554);
        wr(4'h5, 16'hFFFF);
        rd(4'h5, 16'h0000);
        rd(4'hC, 16'h5554);
        rd(4'hD, 16'hFDFF);
        $display("test reserved done");
        // second reset restores defaults
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        rd(4'hC, 16'h0004);
        chk(20'(duty_cycle_stabilizer_on), 20'h00001, "stabilizer back");
        $display("test rereset done");
        summarize();
    end
endmodule : tb_top
